// ---- hw/ofcs_shadow.v ----
// fuse shadow registers, start-up fuse load with ECC, redundant options and lock
`timescale 1ns/1ps
`include "ofcs_map.vh"

module ofcs_shadow (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// register access from the I2C slave front end
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_q,
	output reg         reg_ack_q,
	output reg         reg_err_q,
	// fuse array read port
	output reg         fuse_rd_req_q,
	output reg  [3:0]  fuse_rd_bank_q,
	input  wire        fuse_rd_valid,
	input  wire [25:0] fuse_rd_data,
	// fuse programming gate
	input  wire        fuse_prog_req,
	output reg         fuse_prog_go_q,
	output reg         fuse_prog_refused_q,
	// start-up state
	output reg         load_done_q,
	output reg         fuse_lock_q,
	output reg         ecc_error_q,
	// effective power-up options
	output reg  [1:0]  sequence_delay_q,
	output reg  [1:0]  startup_slew_q,
	output reg         power_button_cfg_q,
	output reg         fuse_load_select_q,
	output reg         power_good_enable_q,
	output reg  [3:0]  ldo5_voltage_code_q,
	output reg  [4:0]  ldo5_sequence_slot_q,
	output reg  [3:0]  ldo6_voltage_code_q,
	output reg  [4:0]  ldo6_sequence_slot_q,
	// decoded configuration towards the regulators
	output reg  [1:0]  buck1_phase_config_q,
	output reg  [1:0]  buck3_phase_config_q,
	output reg         termination_tracking_enable_q
);

	localparam [4:0] ST_REQ10  = 5'b00001;
	localparam [4:0] ST_WAIT10 = 5'b00010;
	localparam [4:0] ST_REQB   = 5'b00100;
	localparam [4:0] ST_WAITB  = 5'b01000;
	localparam [4:0] ST_RUN    = 5'b10000;

	// writable bits of a shadow address, zero when unmapped
	function [7:0] addr_mask;
		input [7:0] a;
		begin
			case (a)
				`OFCS_ADDR_B1P_VOLT,
				`OFCS_ADDR_B1T_VOLT: addr_mask = `OFCS_MASK_VOLT6;
				`OFCS_ADDR_B2_VOLT,
				`OFCS_ADDR_B3A_VOLT,
				`OFCS_ADDR_B3B_VOLT,
				`OFCS_ADDR_B4_VOLT:  addr_mask = `OFCS_MASK_VOLT7;
				`OFCS_ADDR_B1P_SEQ,
				`OFCS_ADDR_B1T_SEQ,
				`OFCS_ADDR_B2_SEQ,
				`OFCS_ADDR_B3A_SEQ,
				`OFCS_ADDR_B3B_SEQ,
				`OFCS_ADDR_B4_SEQ,
				`OFCS_ADDR_BST_SEQ:  addr_mask = `OFCS_MASK_SEQ;
				`OFCS_ADDR_B1P_CFG,
				`OFCS_ADDR_B3A_CFG:  addr_mask = `OFCS_MASK_CFG_PHASE;
				`OFCS_ADDR_B1T_CFG,
				`OFCS_ADDR_B2_CFG,
				`OFCS_ADDR_B3B_CFG:  addr_mask = `OFCS_MASK_CFG_FREQ;
				`OFCS_ADDR_B4_CFG:   addr_mask = `OFCS_MASK_CFG_TRACK;
				`OFCS_ADDR_BST_VOLT: addr_mask = `OFCS_MASK_BST_VOLT;
				default:             addr_mask = 8'h00;
			endcase
		end
	endfunction

	// array index of a shadow address
	function [4:0] sidx;
		input [7:0] a;
		reg [7:0] off;
		begin
			off  = a - `OFCS_ADDR_FIRST;
			sidx = off[4:0];
		end
	endfunction

	// hamming code over 19 data bits, check bits 24:20, overall parity 25
	// returns {uncorrectable, corrected data}
	function [19:0] ecc_fix;
		input [25:0] w;
		integer i;
		reg [4:0]  pos;
		reg [4:0]  syn;
		reg        par;
		reg [18:0] d;
		begin
			d   = w[18:0];
			syn = w[24:20];
			par = ^w;
			pos = 5'd3;
			for (i = 0; i < 19; i = i + 1) begin
				if (d[i])
					syn = syn ^ pos;
				pos = pos + 5'd1;
				if (pos == 5'd4 || pos == 5'd8 || pos == 5'd16)
					pos = pos + 5'd1;
			end
			pos = 5'd3;
			for (i = 0; i < 19; i = i + 1) begin
				if (par && syn == pos)
					d[i] = ~d[i];
				pos = pos + 5'd1;
				if (pos == 5'd4 || pos == 5'd8 || pos == 5'd16)
					pos = pos + 5'd1;
			end
			ecc_fix = {(syn != 5'd0) && !par, d};
		end
	endfunction

	reg [7:0]  shd_q [0:29];
	reg [4:0]  st_q;
	integer    k;

	wire [19:0] fix_w    = ecc_fix(fuse_rd_data);
	wire        ecc_on_w = fuse_rd_data[`OFCS_FUSE_ECC_EN];
	wire [18:0] bank_w   = ecc_on_w ? fix_w[18:0] : fuse_rd_data[18:0];
	wire        bad_w    = ecc_on_w & fix_w[19];
	wire        got_w    = fuse_rd_valid & (st_q == ST_WAIT10 || st_q == ST_WAITB);

	wire [7:0]  wmask_w  = addr_mask(reg_addr);
	wire [4:0]  widx_w   = sidx(reg_addr);
	// writes held off while the fuse load may still overwrite shadows
	wire        wr_ok_w  = reg_wr & (wmask_w != 8'h00) & load_done_q & !fuse_lock_q;
	wire [7:0]  rmask_w  = addr_mask(reg_addr);

	// start-up fuse load sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q           <= ST_REQ10;
			fuse_rd_req_q  <= 1'b0;
			fuse_rd_bank_q <= 4'd0;
			load_done_q    <= 1'b0;
		end else begin
			fuse_rd_req_q <= 1'b0;
			case (st_q)
				ST_REQ10: begin
					fuse_rd_req_q  <= 1'b1;
					fuse_rd_bank_q <= `OFCS_BANK_TEN;
					st_q           <= ST_WAIT10;
				end
				ST_WAIT10: begin
					if (fuse_rd_valid) begin
						if (bank_w[`OFCS_B10_LOAD1] ^ bank_w[`OFCS_B10_LOAD2] ^
						    bank_w[`OFCS_B10_LOAD3]) begin
							fuse_rd_bank_q <= `OFCS_BANK_FIRST;
							st_q           <= ST_REQB;
						end else begin
							load_done_q <= 1'b1;
							st_q        <= ST_RUN;
						end
					end
				end
				ST_REQB: begin
					fuse_rd_req_q <= 1'b1;
					st_q          <= ST_WAITB;
				end
				ST_WAITB: begin
					if (fuse_rd_valid) begin
						if (fuse_rd_bank_q == `OFCS_BANK_NINE) begin
							load_done_q <= 1'b1;
							st_q        <= ST_RUN;
						end else begin
							// linear regulator banks seven and eight belong elsewhere
							if (fuse_rd_bank_q == `OFCS_BANK_LAST_BUCK)
								fuse_rd_bank_q <= `OFCS_BANK_NINE;
							else
								fuse_rd_bank_q <= fuse_rd_bank_q + 4'd1;
							st_q <= ST_REQB;
						end
					end
				end
				ST_RUN: begin
					st_q <= ST_RUN;
				end
				default: begin
					st_q <= ST_REQ10;
				end
			endcase
		end
	end

	// bank ten options, bank nine fields, ECC status
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sequence_delay_q     <= 2'b00;
			startup_slew_q       <= 2'b00;
			power_button_cfg_q   <= 1'b0;
			fuse_load_select_q   <= 1'b0;
			fuse_lock_q          <= 1'b0;
			power_good_enable_q  <= 1'b0;
			ldo5_voltage_code_q  <= 4'h0;
			ldo5_sequence_slot_q <= 5'h00;
			ldo6_voltage_code_q  <= 4'h0;
			ldo6_sequence_slot_q <= 5'h00;
			ecc_error_q          <= 1'b0;
		end else begin
			if (got_w && bad_w)
				ecc_error_q <= 1'b1;
			if (fuse_rd_valid && st_q == ST_WAIT10) begin
				sequence_delay_q   <= bank_w[`OFCS_B10_SEQ1] ^ bank_w[`OFCS_B10_SEQ2] ^
				                      bank_w[`OFCS_B10_SEQ3];
				startup_slew_q     <= bank_w[`OFCS_B10_SLEW1] ^ bank_w[`OFCS_B10_SLEW2] ^
				                      bank_w[`OFCS_B10_SLEW3];
				power_button_cfg_q <= bank_w[`OFCS_B10_BTN1] ^ bank_w[`OFCS_B10_BTN2] ^
				                      bank_w[`OFCS_B10_BTN3];
				fuse_load_select_q <= bank_w[`OFCS_B10_LOAD1] ^ bank_w[`OFCS_B10_LOAD2] ^
				                      bank_w[`OFCS_B10_LOAD3];
				fuse_lock_q        <= bank_w[`OFCS_B10_LOCK];
			end
			if (fuse_rd_valid && st_q == ST_WAITB && fuse_rd_bank_q == `OFCS_BANK_NINE) begin
				ldo5_voltage_code_q  <= bank_w[`OFCS_B9_LDO5_VOLT];
				ldo5_sequence_slot_q <= bank_w[`OFCS_B9_LDO5_SEQ];
				ldo6_voltage_code_q  <= bank_w[`OFCS_B9_LDO6_VOLT];
				ldo6_sequence_slot_q <= bank_w[`OFCS_B9_LDO6_SEQ];
				power_good_enable_q  <= bank_w[`OFCS_B9_PGOOD];
			end
		end
	end

	// shadow array: fuse load during start-up, host writes afterwards
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < 30; k = k + 1)
				shd_q[k] <= `OFCS_SHADOW_RESET;
		end else if (fuse_rd_valid && st_q == ST_WAITB) begin
			case (fuse_rd_bank_q)
				4'd1: begin
					shd_q[sidx(`OFCS_ADDR_B1P_VOLT)] <= {2'b00, bank_w[5:0]};
					shd_q[sidx(`OFCS_ADDR_B1P_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B1P_CFG)]  <= {4'h0, bank_w[15:12]};
				end
				4'd2: begin
					shd_q[sidx(`OFCS_ADDR_B1T_VOLT)] <= {2'b00, bank_w[5:0]};
					shd_q[sidx(`OFCS_ADDR_B1T_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B1T_CFG)]  <= {6'h00, bank_w[13:12]};
					shd_q[sidx(`OFCS_ADDR_BST_VOLT)] <= {6'h00, bank_w[15:14]};
				end
				4'd3: begin
					shd_q[sidx(`OFCS_ADDR_B2_VOLT)] <= {1'b0, bank_w[6:0]};
					shd_q[sidx(`OFCS_ADDR_B2_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B2_CFG)]  <= {6'h00, bank_w[13:12]};
					shd_q[sidx(`OFCS_ADDR_BST_SEQ)] <= {3'b000, bank_w[18:14]};
				end
				4'd4: begin
					shd_q[sidx(`OFCS_ADDR_B3A_VOLT)] <= {1'b0, bank_w[6:0]};
					shd_q[sidx(`OFCS_ADDR_B3A_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B3A_CFG)]  <= {4'h0, bank_w[15:12]};
				end
				4'd5: begin
					shd_q[sidx(`OFCS_ADDR_B3B_VOLT)] <= {1'b0, bank_w[6:0]};
					shd_q[sidx(`OFCS_ADDR_B3B_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B3B_CFG)]  <= {6'h00, bank_w[13:12]};
				end
				4'd6: begin
					shd_q[sidx(`OFCS_ADDR_B4_VOLT)] <= {1'b0, bank_w[6:0]};
					shd_q[sidx(`OFCS_ADDR_B4_SEQ)]  <= {3'b000, bank_w[11:7]};
					shd_q[sidx(`OFCS_ADDR_B4_CFG)]  <= {3'b000, bank_w[14], 2'b00, bank_w[13:12]};
				end
				default: begin
				end
			endcase
		end else if (wr_ok_w) begin
			shd_q[widx_w] <= reg_wdata & wmask_w;
		end
	end

	// host register answers, one cycle after the strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
			reg_ack_q   <= 1'b0;
			reg_err_q   <= 1'b0;
		end else begin
			reg_ack_q <= reg_wr | reg_rd;
			reg_err_q <= reg_wr & !wr_ok_w;
			if (reg_rd) begin
				if (reg_addr == `OFCS_ADDR_OPT_XOR)
					reg_rdata_q <= {3'b000, power_button_cfg_q,
					                startup_slew_q, sequence_delay_q};
				else if (rmask_w != 8'h00)
					reg_rdata_q <= shd_q[widx_w] & rmask_w;
				else
					reg_rdata_q <= 8'h00;
			end
		end
	end

	// programming gate and decoded regulator configuration
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_prog_go_q                <= 1'b0;
			fuse_prog_refused_q           <= 1'b0;
			buck1_phase_config_q          <= 2'b00;
			buck3_phase_config_q          <= 2'b00;
			termination_tracking_enable_q <= 1'b0;
		end else begin
			// no burning until the load has settled the lock state
			fuse_prog_go_q      <= fuse_prog_req & load_done_q & !fuse_lock_q;
			fuse_prog_refused_q <= fuse_prog_req & (fuse_lock_q | !load_done_q);
			buck1_phase_config_q <= shd_q[sidx(`OFCS_ADDR_B1P_CFG)][3:2];
			buck3_phase_config_q <= shd_q[sidx(`OFCS_ADDR_B3A_CFG)][3:2];
			termination_tracking_enable_q <= shd_q[sidx(`OFCS_ADDR_B4_CFG)][4];
		end
	end

endmodule

// ---- hw/ofcs_map.vh ----
// address map, field positions and fuse layout of the fuse shadow block
`ifndef OFCS_MAP_VH
`define OFCS_MAP_VH

// shadow register byte addresses
`define OFCS_ADDR_FIRST       8'hA0
`define OFCS_ADDR_LAST        8'hBD
`define OFCS_ADDR_B1P_VOLT    8'hA0
`define OFCS_ADDR_B1P_SEQ     8'hA1
`define OFCS_ADDR_B1P_CFG     8'hA2
`define OFCS_ADDR_B1T_VOLT    8'hA8
`define OFCS_ADDR_B1T_SEQ     8'hA9
`define OFCS_ADDR_B1T_CFG     8'hAA
`define OFCS_ADDR_B2_VOLT     8'hAC
`define OFCS_ADDR_B2_SEQ      8'hAD
`define OFCS_ADDR_B2_CFG      8'hAE
`define OFCS_ADDR_B3A_VOLT    8'hB0
`define OFCS_ADDR_B3A_SEQ     8'hB1
`define OFCS_ADDR_B3A_CFG     8'hB2
`define OFCS_ADDR_B3B_VOLT    8'hB4
`define OFCS_ADDR_B3B_SEQ     8'hB5
`define OFCS_ADDR_B3B_CFG     8'hB6
`define OFCS_ADDR_B4_VOLT     8'hB8
`define OFCS_ADDR_B4_SEQ      8'hB9
`define OFCS_ADDR_B4_CFG      8'hBA
`define OFCS_ADDR_BST_VOLT    8'hBC
`define OFCS_ADDR_BST_SEQ     8'hBD
// read-only combined redundant options
`define OFCS_ADDR_OPT_XOR     8'hE3

// writable-bit masks, unused bits read zero
`define OFCS_MASK_VOLT6       8'h3F
`define OFCS_MASK_VOLT7       8'h7F
`define OFCS_MASK_SEQ         8'h1F
`define OFCS_MASK_CFG_PHASE   8'h0F
`define OFCS_MASK_CFG_FREQ    8'h03
`define OFCS_MASK_CFG_TRACK   8'h13
`define OFCS_MASK_BST_VOLT    8'h03
`define OFCS_SHADOW_RESET     8'h00

// fuse bank geometry
`define OFCS_BANK_W           26
`define OFCS_BANK_FIRST       4'd1
`define OFCS_BANK_LAST_BUCK   4'd6
`define OFCS_BANK_NINE        4'd9
`define OFCS_BANK_TEN         4'd10
`define OFCS_FUSE_ECC_EN      19

// bank ten redundant copies and single lock fuse
`define OFCS_B10_SEQ1         1:0
`define OFCS_B10_SEQ2         7:6
`define OFCS_B10_SEQ3         13:12
`define OFCS_B10_SLEW1        3:2
`define OFCS_B10_SLEW2        9:8
`define OFCS_B10_SLEW3        15:14
`define OFCS_B10_BTN1         4
`define OFCS_B10_BTN2         10
`define OFCS_B10_BTN3         16
`define OFCS_B10_LOAD1        5
`define OFCS_B10_LOAD2        11
`define OFCS_B10_LOAD3        17
`define OFCS_B10_LOCK         18

// bank nine fields
`define OFCS_B9_LDO5_VOLT     3:0
`define OFCS_B9_LDO5_SEQ      8:4
`define OFCS_B9_LDO6_VOLT     12:9
`define OFCS_B9_LDO6_SEQ      17:13
`define OFCS_B9_PGOOD         18

`endif

// ---- tb/ofcs_shadow_sva.sv ----
// assertion checker for the fuse shadow block
`timescale 1ns/1ps
module ofcs_shadow_chk (
	// clock and reset
	input wire       clk,
	input wire       rst_n,
	// register port
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata_q,
	input wire       reg_ack_q,
	input wire       reg_err_q,
	// fuse side
	input wire       fuse_rd_req_q,
	input wire [3:0] fuse_rd_bank_q,
	input wire       fuse_rd_valid,
	input wire       fuse_prog_req,
	input wire       fuse_prog_go_q,
	input wire       fuse_prog_refused_q,
	// state and options
	input wire       load_done_q,
	input wire       fuse_lock_q,
	input wire [1:0] sequence_delay_q,
	input wire [1:0] startup_slew_q,
	input wire       power_button_cfg_q,
	input wire       fuse_load_select_q,
	input wire [1:0] buck1_phase_config_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_b1p;
		reg_wr && reg_addr == 8'hA2 ##1 reg_ack_q && !reg_err_q;
	endsequence
	sequence s_ten_noload;
		fuse_rd_valid && fuse_rd_bank_q == 4'hA && !load_done_q ##1 !fuse_load_select_q;
	endsequence
	a_ack_on_strobe: assert property ((reg_wr || reg_rd) |=> reg_ack_q)
		else $error("no answer after strobe");
	a_ack_no_strobe: assert property (!(reg_wr || reg_rd) |=> !reg_ack_q)
		else $error("answer without strobe");
	a_read_no_err: assert property (reg_rd |=> !reg_err_q)
		else $error("read flagged as refused");
	a_unmapped_wr_err: assert property (reg_wr && (reg_addr < 8'hA0 || reg_addr > 8'hBD)
		|=> reg_err_q) else $error("unmapped write accepted");
	a_lock_wr_err: assert property (reg_wr && fuse_lock_q |=> reg_err_q)
		else $error("write accepted while locked");
	a_lock_prog_refuse: assert property (fuse_prog_req && fuse_lock_q
		|=> fuse_prog_refused_q && !fuse_prog_go_q) else $error("programming while locked");
	a_prog_grant: assert property (fuse_prog_req && load_done_q && !fuse_lock_q
		|=> fuse_prog_go_q) else $error("allowed programming not granted");
	a_bank_gate: assert property (fuse_rd_req_q && fuse_rd_bank_q != 4'hA
		|-> fuse_load_select_q) else $error("bank read without load select");
	a_ten_only_done: assert property (s_ten_noload |-> load_done_q)
		else $error("load not finished after option bank");
	a_nine_done: assert property (fuse_rd_valid && fuse_rd_bank_q == 4'h9 && !load_done_q
		|=> load_done_q) else $error("load not finished after bank nine");
	a_xor_readback: assert property (reg_rd && reg_addr == 8'hE3
		|=> reg_rdata_q == {3'b000, $past(power_button_cfg_q), $past(startup_slew_q),
		$past(sequence_delay_q)})
		else $error("combined option read mismatch");
	a_phase_follow: assert property (s_wr_b1p
		|=> buck1_phase_config_q == $past(reg_wdata[3:2], 2)) else $error("phase not updated");
	a_volt_mask: assert property (reg_rd && reg_addr == 8'hA0 |=> reg_rdata_q[7:6] == 2'b00)
		else $error("unused voltage bits read set");
endmodule
bind ofcs_shadow ofcs_shadow_chk ofcs_shadow_chk_inst (.*);

// ---- tb/ofcs_fuse_model.sv ----
// behavioural fuse array answering bank reads after a set latency
`timescale 1ns/1ps
module ofcs_fuse_model (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// bank read port
	input  wire        fuse_rd_req_q,
	input  wire [3:0]  fuse_rd_bank_q,
	output reg         fuse_rd_valid,
	output reg  [25:0] fuse_rd_data
);
	reg     [25:0] fuses [1:10];
	integer        lat = 1;
	integer        cnt;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_rd_valid <= 1'b0;
			fuse_rd_data  <= 26'h0000000;
			cnt           <= 0;
		end else begin
			fuse_rd_valid <= 1'b0;
			// stale data inverted so nothing leans on it
			if (fuse_rd_valid)
				fuse_rd_data <= ~fuse_rd_data;
			if (fuse_rd_req_q)
				cnt <= lat;
			else if (cnt == 1) begin
				fuse_rd_valid <= 1'b1;
				fuse_rd_data  <= fuses[fuse_rd_bank_q];
				cnt           <= 0;
			end else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule

// ---- tb/tb_ofcs_shadow.sv ----
// self-checking bench for the fuse shadow block
`timescale 1ns/1ps
module tb_ofcs_shadow;
	reg          clk = 1'b0;
	reg          rst_n = 1'b0;
	reg          reg_wr = 1'b0;
	reg          reg_rd = 1'b0;
	reg  [7:0]   reg_addr = 8'h00;
	reg  [7:0]   reg_wdata = 8'h00;
	reg          fuse_prog_req = 1'b0;
	wire [7:0]   reg_rdata_q;
	wire         reg_ack_q, reg_err_q, fuse_rd_req_q, fuse_rd_valid, fuse_prog_go_q;
	wire         fuse_prog_refused_q, load_done_q, fuse_lock_q, ecc_error_q;
	wire         power_button_cfg_q, fuse_load_select_q, power_good_enable_q;
	wire         termination_tracking_enable_q;
	wire [1:0]   sequence_delay_q, startup_slew_q, buck1_phase_config_q, buck3_phase_config_q;
	wire [3:0]   fuse_rd_bank_q, ldo5_voltage_code_q, ldo6_voltage_code_q;
	wire [4:0]   ldo5_sequence_slot_q, ldo6_sequence_slot_q;
	wire [25:0]  fuse_rd_data;
	integer      miscompares = 0;
	integer      cmp_count = 0;
	integer      i, n;
	reg  [7:0]   rd;
	reg          e;
	reg  [191:0] tbl;
	ofcs_shadow ofcs_shadow_inst (.*);
	ofcs_fuse_model ofcs_fuse_model_inst (.*);
	always #12.5 clk = ~clk;
	task report_and_stop;
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task check(input string nm, input [25:0] seen, input [25:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task xfer(input w, input [7:0] a, input [7:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		check("ack", reg_ack_q, 1'b1);
		rd = reg_rdata_q;
		e = reg_err_q;
	endtask
	// hamming code over data fuses, fuse 19 set, fuse 25 evens the word
	function [25:0] enc(input [18:0] d);
		reg [4:0] s;
		integer k;
		s = 5'h00;
		for (k = 0; k < 19; k = k + 1)
			if (d[k])
				s = s ^ 5'(k == 0 ? 3 : k < 4 ? k + 4 : k < 11 ? k + 5 : k + 6);
		enc = {1'b0, s, 1'b1, d};
		enc[25] = ^enc[24:0];
	endfunction
	task boot(input integer lat);
		ofcs_fuse_model_inst.lat = lat;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		fuse_prog_req <= 1'b1;
		@(posedge clk);
		fuse_prog_req <= 1'b0;
		#1;
		check("early_prog", fuse_prog_refused_q, 1'b1);
		n = 0;
		while (load_done_q !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
		if (load_done_q !== 1'b1) begin
			check("load_wait", 1'b0, 1'b1);
			report_and_stop;
		end
		@(posedge clk);
		#1;
	endtask
	task t_startup;
		ofcs_fuse_model_inst.fuses[1] = 26'h00099AA;
		ofcs_fuse_model_inst.fuses[2] = 26'h000C000;
		ofcs_fuse_model_inst.fuses[3] = 26'h0034000;
		ofcs_fuse_model_inst.fuses[4] = enc(19'h0D1AC) ^ 26'h0000004;
		ofcs_fuse_model_inst.fuses[5] = 26'h0000000;
		ofcs_fuse_model_inst.fuses[6] = 26'h000636F;
		ofcs_fuse_model_inst.fuses[9] = 26'h0051ECA;
		ofcs_fuse_model_inst.fuses[10] = 26'h00104F9;
		boot(1);
		check("seq_delay", sequence_delay_q, 2'b10);
		check("slew", startup_slew_q, 2'b10);
		check("button", power_button_cfg_q, 1'b1);
		check("load_sel", fuse_load_select_q, 1'b1);
		check("pgood", power_good_enable_q, 1'b1);
		check("ldo", {ldo5_voltage_code_q, ldo5_sequence_slot_q, ldo6_voltage_code_q,
			ldo6_sequence_slot_q}, {4'hA, 5'h0C, 4'hF, 5'h08});
		check("ecc_err", ecc_error_q, 1'b0);
		check("modes", {buck1_phase_config_q, buck3_phase_config_q,
			termination_tracking_enable_q}, 5'b10111);
		xfer(1'b0, 8'hE3, 8'h00);
		check("opt_xor", rd, 8'h1A);
		tbl = {16'hA02A, 16'hA113, 16'hA209, 16'hB02C, 16'hB103, 16'hB20D,
			16'hB86F, 16'hB906, 16'hBA12, 16'hBC03, 16'hBD0D};
		for (i = 0; i < 11; i = i + 1) begin
			xfer(1'b0, tbl[175 - 16 * i -: 8], 8'h00);
			check("loaded", rd, tbl[167 - 16 * i -: 8]);
		end
	endtask
	task t_masks;
		// last entry: the read-only option register must refuse and keep its value
		tbl = {16'hA03F, 16'hA11F, 16'hA20F, 16'hAA03, 16'hAC7F, 16'hB20F,
			16'hB603, 16'hBA13, 16'hBC03, 16'hBD1F, 16'hA300, 16'hE31A};
		for (i = 0; i < 12; i = i + 1) begin
			xfer(1'b1, tbl[191 - 16 * i -: 8], 8'hFF);
			check("wr_err", e, tbl[191 - 16 * i -: 8] == 8'hA3 ||
				tbl[191 - 16 * i -: 8] > 8'hBD);
			xfer(1'b0, tbl[191 - 16 * i -: 8], 8'h00);
			check("masked", rd, tbl[183 - 16 * i -: 8]);
		end
		check("modes", {buck1_phase_config_q, buck3_phase_config_q,
			termination_tracking_enable_q}, 5'b11111);
		@(posedge clk);
		fuse_prog_req <= 1'b1;
		@(posedge clk);
		fuse_prog_req <= 1'b0;
		#1;
		check("prog_go", fuse_prog_go_q, 1'b1);
	endtask
	task t_codes;
		for (i = 0; i < 4; i = i + 1) begin
			xfer(1'b1, 8'hAE, 8'(i));
			xfer(1'b0, 8'hAE, 8'h00);
			check("freq", rd, 8'(i));
			xfer(1'b1, 8'hA2, 8'(i * 5));
			xfer(1'b1, 8'hB2, 8'(i * 5));
			@(posedge clk);
			#1;
			check("phase", {buck1_phase_config_q, buck3_phase_config_q},
				{2'(i), 2'(i)});
		end
	endtask
	task t_lock;
		// lock only, ECC on, two check fuses flipped: flagged, data kept raw
		ofcs_fuse_model_inst.fuses[10] = enc(19'h40000) ^ 26'h0300000;
		boot(4);
		check("lock", fuse_lock_q, 1'b1);
		check("ecc_double", ecc_error_q, 1'b1);
		check("load_sel", fuse_load_select_q, 1'b0);
		xfer(1'b0, 8'hA0, 8'h00);
		check("not_loaded", rd, 8'h00);
		xfer(1'b1, 8'hA1, 8'h05);
		check("lock_err", e, 1'b1);
		xfer(1'b0, 8'hA1, 8'h00);
		check("lock_keep", rd, 8'h00);
		@(posedge clk);
		fuse_prog_req <= 1'b1;
		@(posedge clk);
		fuse_prog_req <= 1'b0;
		#1;
		check("lock_prog", {fuse_prog_refused_q, fuse_prog_go_q}, 2'b10);
	endtask
	initial begin
		t_startup;
		t_masks;
		t_codes;
		t_lock;
		report_and_stop;
	end
endmodule
